//--- verilog/sssp_core.sv
// Synchronous serial shift port with APB register access
`timescale 1ns/1ps
module sssp_core
  import sssp_pkg::*;
#(
  parameter int INSTR_CLKS = SSSP_INSTR_CLKS_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire ssspPinIn_t pinIn,
  output logic sckOut,
  output logic sckOeN,
  output logic sdoOut,
  output logic sdoOeN,
  // Processor side
  output logic testSense,
  output logic aleStrobe
);

  // Clocks of each shift clock phase
  localparam int HIGH_DIV1 = (INSTR_CLKS * SSSP_DUTY_DIV1_PCT) / 100;
  localparam int HIGH_DIV4 = SSSP_DIV_SLOW / 2;
  localparam logic [15:0] PH_LAST = 16'(INSTR_CLKS - 1);
  localparam logic [15:0] PH_HIGH1 = 16'(HIGH_DIV1);
  localparam logic [1:0] CYC_LAST = 2'(SSSP_DIV_SLOW - 1);
  localparam logic [1:0] CYC_HIGH4 = 2'(HIGH_DIV4);

  // Synchronised pins
  ssspPinIn_t pinSync;

  // Instruction cycle timing
  logic [15:0] phase_q;
  logic [15:0] phase_d;
  logic [1:0] cyc_q;
  logic [1:0] cyc_d;
  logic ale_q;
  logic ale_d;

  // Shift clock generator
  logic run_q;
  logic run_d;
  logic sck_q;
  logic sck_d;
  logic slvPrev_q;
  logic slvPrev_d;

  // Serial engine
  ssspMode_t mode_q;
  ssspMode_t mode_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic done_q;
  logic done_d;
  logic sdo_q;
  logic sdo_d;

  // Port 2 latches and bus read data
  logic [7:0] port2_q;
  logic [7:0] port2_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Bus decode
  logic setupPh;
  logic accessPh;
  logic wrXchg;
  logic wrPort2;
  logic mapped;
  logic [7:0] wrOpc;
  logic doMaster;
  logic doSlave;
  logic doXchg;

  // Edge events seen by the engine
  logic periodStart;
  logic highPhase;
  logic riseEv;
  logic fallEv;
  logic slowRate;

  ssspStatus_t status;

  // Bring clock, data and test pins into the clock domain
  sssp_sync2 #(
    .W($bits(ssspPinIn_t))
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  // APB address decode and exchange command decode
  always_comb begin
    setupPh = psel && !penable;
    accessPh = psel && penable;
    mapped = (paddr == SSSP_ADDR_XCHG) || (paddr == SSSP_ADDR_PORT2) ||
             (paddr == SSSP_ADDR_STATUS);
    wrXchg = accessPh && pwrite && (paddr == SSSP_ADDR_XCHG) &&
             pstrb[0] && pstrb[1];
    wrPort2 = accessPh && pwrite && (paddr == SSSP_ADDR_PORT2) && pstrb[0];
    wrOpc = pwdata[SSSP_OPC_LSB +: 8];
    doMaster = wrXchg && (wrOpc == SSSP_OPC_MASTER);
    doSlave = wrXchg && (wrOpc == SSSP_OPC_SLAVE);
    doXchg = doMaster || doSlave;
  end

  // Zero-wait answer; unmapped addresses flag an error
  assign pready = accessPh;
  assign pslverr = accessPh && !mapped;
  assign prdata = rdata_q;

  // Instruction cycle phase and address strobe
  always_comb begin
    phase_d = (phase_q == PH_LAST) ? 16'h0000 : phase_q + 16'h0001;
    cyc_d = cyc_q;
    if (phase_q == PH_LAST) begin
      cyc_d = (cyc_q == CYC_LAST) ? 2'h0 : cyc_q + 2'h1;
    end
    // Strobe rises with the start of every instruction cycle
    ale_d = (phase_d == 16'h0000);
  end

  // Register instruction timing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 16'h0000;
      cyc_q <= 2'h0;
      ale_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cyc_q <= cyc_d;
      ale_q <= ale_d;
    end
  end

  assign aleStrobe = ale_q;

  // Master shift clock shape from the rate latch
  always_comb begin
    slowRate = port2_q[SSSP_RATE_BIT];
    if (slowRate) begin
      // Four instruction cycles, high for the first two
      periodStart = (phase_d == 16'h0000) && (cyc_d == 2'h0);
      highPhase = (cyc_d < CYC_HIGH4);
    end else begin
      // One instruction cycle, high for forty percent of it
      periodStart = (phase_d == 16'h0000);
      highPhase = (phase_d < PH_HIGH1);
    end
  end

  // Clock generation gate and slave edge detect
  always_comb begin
    run_d = run_q;
    // Gate changes only at a period start, where no pulse is cut short, or at once when a slave exchange leaves master mode, which can cut a high pulse short
    // Registered done lets the eighth pulse finish and keeps the gate
    // out of the edge path; an exchange on a period start waits one
    // period so no pulse rises without being counted
    if (periodStart) begin
      run_d = (mode_q == SSSP_MASTER) && !done_q && !doXchg;
    end
    if (mode_d != SSSP_MASTER) begin
      run_d = 1'b0;
    end
    sck_d = run_d && highPhase;
    slvPrev_d = pinSync.sck;
    riseEv = 1'b0;
    fallEv = 1'b0;
    case (mode_q)
      SSSP_MASTER: begin
        riseEv = sck_d && !sck_q;
        fallEv = !sck_d && sck_q;
      end
      SSSP_SLAVE: begin
        // External clock edges only after synchronising
        riseEv = pinSync.sck && !slvPrev_q;
        fallEv = !pinSync.sck && slvPrev_q;
      end
      default: begin
        riseEv = 1'b0;
        fallEv = 1'b0;
      end
    endcase
  end

  // Register clock generator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q <= 1'b0;
      sck_q <= 1'b0;
      slvPrev_q <= 1'b0;
    end else begin
      run_q <= run_d;
      sck_q <= sck_d;
      slvPrev_q <= slvPrev_d;
    end
  end

  // Mode, exchange, shifting, counting and done flag
  always_comb begin
    mode_d = mode_q;
    shift_d = shift_q;
    acc_d = acc_q;
    count_d = count_q;
    done_d = done_q;
    sdo_d = sdo_q;
    case (mode_q)
      SSSP_PORT: begin
        // Normal port mode until an exchange arrives
        mode_d = SSSP_PORT;
      end
      SSSP_MASTER, SSSP_SLAVE: begin
        // Serial mode stays until system reset
        mode_d = mode_q;
      end
      default: begin
        mode_d = SSSP_PORT;
      end
    endcase
    if (doXchg) begin
      // Swap accumulator with shift register and restart the count
      mode_d = doMaster ? SSSP_MASTER : SSSP_SLAVE;
      acc_d = shift_q;
      shift_d = pwdata[SSSP_ACC_LSB +: 8];
      count_d = 4'h0;
      done_d = 1'b0;
      sdo_d = pwdata[SSSP_ACC_LSB + 7];
    end else begin
      if (riseEv && (count_q != SSSP_BITS)) begin
        // Sample serial input, count the pulse
        shift_d = {shift_q[6:0], pinSync.sdi};
        count_d = count_q + 4'h1;
      end
      if (fallEv) begin
        // Present the next transmit bit
        sdo_d = shift_q[7];
      end
    end
    // Done set wins over a clear in the same cycle
    if (riseEv && (count_q == SSSP_BITS - 4'h1)) begin
      done_d = 1'b1;
    end
  end

  // Register serial engine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= SSSP_PORT;
      shift_q <= 8'h00;
      acc_q <= 8'h00;
      count_q <= 4'h0;
      done_q <= 1'b0;
      sdo_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      shift_q <= shift_d;
      acc_q <= acc_d;
      count_q <= count_d;
      done_q <= done_d;
      sdo_q <= sdo_d;
    end
  end

  // Status word
  always_comb begin
    status.done = done_q;
    status.mode = mode_q;
    status.count = count_q;
  end

  // Port 2 latches and read data captured in the setup phase
  always_comb begin
    port2_d = port2_q;
    if (wrPort2) begin
      // Latches stay writable in every mode
      port2_d = pwdata[7:0];
    end
    rdata_d = rdata_q;
    if (setupPh && !pwrite) begin
      case (paddr)
        SSSP_ADDR_XCHG: begin
          rdata_d = {24'h000000, acc_q};
        end
        SSSP_ADDR_PORT2: begin
          rdata_d = {24'h000000, port2_q};
          if (mode_q != SSSP_PORT) begin
            // Serial pins show in place of their latches
            rdata_d[SSSP_SO_BIT] = sdoOut;
            rdata_d[SSSP_SI_BIT] = pinSync.sdi;
          end
        end
        SSSP_ADDR_STATUS: begin
          rdata_d = {{(32 - $bits(ssspStatus_t)){1'b0}}, status};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // Register latches and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port2_q <= SSSP_PORT2_RST;
      rdata_q <= 32'h00000000;
    end else begin
      port2_q <= port2_d;
      rdata_q <= rdata_d;
    end
  end

  // Pin drivers; enables are low while driving
  always_comb begin
    sckOut = sck_q;
    sdoOut = sdo_q;
    // Clock pin driven only in master role
    sckOeN = (mode_q != SSSP_MASTER);
    // Serial output tri-stated by the enable latch or in port mode
    sdoOeN = (mode_q == SSSP_PORT) || port2_q[SSSP_OE_BIT];
    // Test sense follows done in serial mode, the pin otherwise
    testSense = (mode_q == SSSP_PORT) ? pinSync.test : done_q;
  end

endmodule : sssp_core

//--- verilog/sssp_pkg.sv
// Constants, types and register map of the synchronous serial shift port
package sssp_pkg;

  // Register byte addresses
  localparam logic [11:0] SSSP_ADDR_XCHG = 12'h000;
  localparam logic [11:0] SSSP_ADDR_PORT2 = 12'h004;
  localparam logic [11:0] SSSP_ADDR_STATUS = 12'h008;

  // Exchange opcodes
  localparam logic [7:0] SSSP_OPC_MASTER = 8'hC0;
  localparam logic [7:0] SSSP_OPC_SLAVE = 8'hC1;

  // Port 2 latch reset value and bit positions
  localparam logic [7:0] SSSP_PORT2_RST = 8'hFF;
  localparam int SSSP_OE_BIT = 6;
  localparam int SSSP_RATE_BIT = 7;
  localparam int SSSP_SO_BIT = 6;
  localparam int SSSP_SI_BIT = 7;

  // Exchange register field positions
  localparam int SSSP_ACC_LSB = 0;
  localparam int SSSP_OPC_LSB = 8;

  // Transfer length and clock shaping
  localparam logic [3:0] SSSP_BITS = 4'h8;
  localparam int SSSP_DIV_SLOW = 4;
  localparam int SSSP_DUTY_DIV1_PCT = 40;
  localparam int SSSP_INSTR_CLKS_DEF = 10;

  // Operating mode
  typedef enum logic [1:0] {
    SSSP_PORT = 2'b00,
    SSSP_MASTER = 2'b01,
    SSSP_SLAVE = 2'b10
  } ssspMode_t;

  // Status word as read back
  typedef struct packed {
    logic done;
    ssspMode_t mode;
    logic [3:0] count;
  } ssspStatus_t;

  // Serial pins entering the block
  typedef struct packed {
    logic sck;
    logic sdi;
    logic test;
  } ssspPinIn_t;

endpackage : sssp_pkg

//--- verilog/sssp_sync2.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sssp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_q; // First stage, read only by second stage
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q; // Second stage
  logic [W-1:0] sync_d;

  // Next values of both stages
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // Register both stages
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule : sssp_sync2

//--- bench/sssp_props.sv
// Concurrent checks on the serial shift port pins
`timescale 1ns/1ps
module sssp_props
  import sssp_pkg::*;
#(
  parameter int INSTR_CLKS = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus request
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Pins
  input wire logic sckOut,
  input wire logic sckOeN,
  input wire logic sdoOut,
  input wire logic sdoOeN,
  input wire logic testSense,
  input wire logic aleStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wrAcc; // Write taken this cycle
  logic xch; // Exchange write
  logic p2Wr; // Latch write
  logic rate_q, rate_d; // Copy of the rate latch
  logic [7:0] hi_q, hi_d; // Cycles the clock has been high
  assign wrAcc = psel && penable && pwrite;
  assign xch = wrAcc && paddr == SSSP_ADDR_XCHG && pstrb[1:0] == 2'h3;
  assign p2Wr = wrAcc && paddr == SSSP_ADDR_PORT2 && pstrb[0];
  // Next helper values
  always_comb begin
    rate_d = p2Wr ? pwdata[SSSP_RATE_BIT] : rate_q;
    hi_d = sckOut ? hi_q + 8'h01 : 8'h00;
  end
  // Helper registers, latch copy comes up as ones
  always_ff @(posedge clk) begin
    rate_q <= sys_rst ? 1'b1 : rate_d;
    hi_q <= sys_rst ? 8'h00 : hi_d;
  end
  a_master_drive:
    assert property (xch && pwdata[15:8] == SSSP_OPC_MASTER |=> !sckOeN)
    else $error("clock pin not driven");
  a_slave_input:
    assert property (xch && pwdata[15:8] == SSSP_OPC_SLAVE |=> sckOeN)
    else $error("clock pin still driven");
  a_exch_clear:
    assert property (xch && pwdata[15:9] == 7'h60 |=> !testSense)
    else $error("done not cleared");
  a_sdo_steady:
    assert property (!sckOeN && $rose(sckOut) && !$past(xch)
      |-> $stable(sdoOut)) else $error("data moved on rise");
  a_oe_off:
    assert property (p2Wr && pwdata[SSSP_OE_BIT] |=> sdoOeN)
    else $error("output still driven");
  a_clk_stops:
    assert property (testSense && !sckOeN && !sckOut && !xch |=> !sckOut)
    else $error("clock ran after done");
  a_rise_ale:
    assert property (!sckOeN && $rose(sckOut) |-> aleStrobe)
    else $error("rise not with strobe");
  a_high_width:
    assert property (!sckOeN && $fell(sckOut) |-> hi_q ==
      (rate_q ? 8'(2 * INSTR_CLKS) : 8'(INSTR_CLKS * 2 / 5)))
    else $error("wrong high time");
  a_done_high:
    assert property (!sckOeN && $rose(testSense) |-> sckOut)
    else $error("done off the rise");
  // Main scenarios
  c_mdone: cover property (!sckOeN && $rose(testSense));
  c_sdone: cover property (sckOeN && !sdoOeN && $rose(testSense));
  c_oeoff: cover property (p2Wr && pwdata[SSSP_OE_BIT]);
endmodule : sssp_props

//--- bench/sssp_peer.sv
// Far-side shift partner: follows or makes the line clock
`timescale 1ns/1ps
module sssp_peer (
  // From the bench
  input wire logic clk,
  input wire logic load,
  input wire logic [7:0] txByte,
  input wire logic genGo,
  // Line side
  input wire logic sckLine,
  input wire logic sdoLine,
  output logic sckGen,
  output logic sdiDrv,
  output logic [7:0] rxByte
);
  logic [7:0] sh = 8'h00; // Outgoing bits
  initial rxByte = 8'h00;
  initial sckGen = 1'b0;
  // New byte to send
  always @(posedge load) sh = txByte;
  // Take a bit on rise, MSB first
  always @(posedge sckLine) rxByte = {rxByte[6:0], sdoLine};
  // Next bit on fall, pull-up level behind
  always @(negedge sckLine) sh = {sh[6:0], 1'b1};
  assign sdiDrv = sh[7];
  // Eight pulses as clock source, idle low between frames
  always @(posedge genGo) begin
    repeat (8) begin
      repeat (5) @(posedge clk);
      sckGen <= 1'b1;
      repeat (5) @(posedge clk);
      sckGen <= 1'b0;
    end
  end
endmodule : sssp_peer

//--- bench/tb_top.sv
// Self-checking bench for the serial shift port
`timescale 1ns/1ps
module tb_top;
  import sssp_pkg::*;
  localparam int IC = 5; // Short instruction cycle
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sErr, sckOut, sckOeN, sdoOut, sdoOeN;
  logic testSense, aleStrobe, sckGen, sdiDrv, sckLine, sdoLine;
  logic load = 1'b0;
  logic genGo = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxByte;
  ssspPinIn_t pinIn;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  // Wire levels: pull-up on data, clock from whoever drives it
  assign sdoLine = sdoOeN ? 1'b1 : sdoOut;
  assign sckLine = sckOeN ? sckGen : sckOut;
  // Test pin held high, so serial mode must hide it behind done
  assign pinIn = {sckLine, sdiDrv, 1'b1};
  sssp_core #(.INSTR_CLKS(IC)) sssp_core_inst (.clk, .sys_rst(sysRst),
    .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pinIn, .sckOut, .sckOeN, .sdoOut, .sdoOeN, .testSense,
    .aleStrobe);
  sssp_peer sssp_peer_inst (.clk, .load, .txByte, .genGo, .sckLine,
    .sdoLine, .sckGen, .sdiDrv, .rxByte);
  always #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // One bus transfer, held until pready is seen
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    sErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One exchange, waits for done and for the clock to stop
  task automatic xfer(input logic [7:0] d, input logic [7:0] t,
    input logic [7:0] op);
    txByte <= t;
    load <= 1'b1;
    apb(SSSP_ADDR_XCHG, 1'b1, {16'h0, op, d});
    load <= 1'b0;
    @(posedge clk);
    cmp(sckOeN, op == SSSP_OPC_SLAVE);
    cmp(testSense, 1'b0);
    if (op == SSSP_OPC_SLAVE)
      genGo <= 1'b1;
    repeat (1000) if (testSense !== 1'b1) @(posedge clk);
    genGo <= 1'b0;
    cmp(testSense, 1'b1);
    repeat (24) @(posedge clk);
  endtask : xfer
  task automatic testReset();
    apb(SSSP_ADDR_PORT2, 1'b0, 32'h0);
    cmp(rd, 32'hFF);
    apb(SSSP_ADDR_STATUS, 1'b0, 32'h0);
    cmp(rd, 32'h0);
    cmp({sckOeN, sdoOeN}, 2'h3);
    apb(SSSP_ADDR_XCHG, 1'b1, 32'h00000012);
    apb(SSSP_ADDR_STATUS, 1'b0, 32'h0);
    cmp(rd, 32'h0);
    cmp(testSense, 1'b1);
    apb(12'h0FC, 1'b0, 32'h0);
    cmp(sErr, 1'b1);
    $display("testReset done");
  endtask : testReset
  task automatic testMaster();
    apb(SSSP_ADDR_PORT2, 1'b1, 32'h3F);
    apb(SSSP_ADDR_PORT2, 1'b0, 32'h0);
    cmp(rd, 32'h3F);
    xfer(8'h3C, 8'hA5, SSSP_OPC_MASTER);
    cmp(rxByte, 8'h3C);
    apb(SSSP_ADDR_STATUS, 1'b0, 32'h0);
    cmp(rd, 32'h58);
    apb(SSSP_ADDR_PORT2, 1'b1, 32'hBF);
    xfer(8'h81, 8'h66, SSSP_OPC_MASTER);
    apb(SSSP_ADDR_XCHG, 1'b0, 32'h0);
    cmp(rd, 32'hA5);
    cmp(rxByte, 8'h81);
    $display("testMaster done");
  endtask : testMaster
  task automatic testSlave();
    xfer(8'h5A, 8'hC3, SSSP_OPC_SLAVE);
    cmp(rxByte, 8'h5A);
    apb(SSSP_ADDR_STATUS, 1'b0, 32'h0);
    cmp(rd, 32'h68);
    xfer(8'h00, 8'h00, SSSP_OPC_MASTER);
    apb(SSSP_ADDR_XCHG, 1'b0, 32'h0);
    cmp(rd, 32'hC3);
    apb(SSSP_ADDR_PORT2, 1'b0, 32'h0);
    cmp(rd[7:6], 2'h2);
    apb(SSSP_ADDR_PORT2, 1'b1, 32'hFF);
    @(posedge clk);
    cmp(sdoOeN, 1'b1);
    $display("testSlave done");
  endtask : testSlave
  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    testReset();
    testMaster();
    testSlave();
    sysRst <= 1'b1;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    testReset();
    summarize();
  end
endmodule : tb_top
bind sssp_core sssp_props #(.INSTR_CLKS(INSTR_CLKS)) sssp_props_inst (
  .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
  .sckOut, .sckOeN, .sdoOut, .sdoOeN, .testSense, .aleStrobe);
